/* File: include/sae_pkg.sv */
// Constants and types shared by both ends of the special function register address extension
package sae_pkg;
    localparam int SFR_BASE = 128;
    localparam logic [7:0] SFR_FIRST = 8'h80;
    localparam logic [7:0] SYSCON_ADDR = 8'h8F;
    localparam logic [7:0] SYSCON_RESET = 8'h04;
    localparam int MAP_SEL_BIT = 0;
    localparam int INTERRUPT_MODE_BIT = 4;
    localparam int FIXED_ONE_BIT = 2;
    localparam logic [7:0] SYSCON_WMASK = 8'h11;
    localparam int PAGE_LSB = 0;
    localparam int PAGE_W = 3;
    localparam int SLOT_LSB = 4;
    localparam int SLOT_W = 2;
    localparam int OPER_LSB = 6;
    localparam int SLOT_COUNT = 4;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam int MODULE_COUNT = 3;
    // Page register addresses in the mapped area, one per paged module
    localparam logic [7:0] PORT_PAGE_ADDR = 8'hB2;
    localparam logic [7:0] ADC_PAGE_ADDR = 8'hD1;
    localparam logic [7:0] SCU_PAGE_ADDR = 8'hBF;
    // Controller command registers
    localparam logic [3:0] CMD_ADDR = 4'h0;
    localparam logic [3:0] CMD_WDATA = 4'h1;
    localparam logic [3:0] CMD_GO = 4'h2;
    localparam logic [3:0] CMD_STATUS = 4'h3;
    localparam logic [3:0] CMD_RDATA = 4'h4;
    localparam logic [3:0] CMD_TARGET = 4'h5;
    typedef enum logic [1:0] {
        OPER_MANUAL0 = 2'b00,
        OPER_MANUAL1 = 2'b01,
        OPER_SAVE = 2'b10,
        OPER_RESTORE = 2'b11
    } sae_oper_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_DONE = 2'b11
    } sae_state_type;
endpackage : sae_pkg

/* File: include/sae_if.sv */
// Special function register access link between processor side and address extension logic
`timescale 1ns/1ps
interface sae_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic mapped;
    logic [2:0] portPage;
    logic [2:0] adcPage;
    logic [2:0] scuPage;
    modport device (input addr, input wdata, input wr, input rd, output rdata, output mapped,
                    output portPage, output adcPage, output scuPage);
    modport core (output addr, output wdata, output wr, output rd, input rdata, input mapped,
                  input portPage, input adcPage, input scuPage);
endinterface : sae_if

/* File: hw/sae_page_reg.sv */
// One module page register with four page storage slots
`timescale 1ns/1ps
module sae_page_reg (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic [7:0] wdata,
    output logic [2:0] page
);
    import sae_pkg::*;
    logic [2:0] page_q;
    logic [2:0] slot_q [SLOT_COUNT];
    sae_oper_type pageOper;
    logic [1:0] slotSel;
    assign pageOper = sae_oper_type'(wdata[OPER_LSB +: 2]);
    assign slotSel = wdata[SLOT_LSB +: SLOT_W];
    assign page = page_q; // R17
    always_ff @(posedge clk) begin
        if (reset) begin
            page_q <= PAGE_RESET[2:0];
        end else if (clkEn && wrEn) begin
            if (pageOper == OPER_RESTORE) begin
                page_q <= slot_q[slotSel]; // R15
            end else begin
                page_q <= wdata[PAGE_LSB +: PAGE_W]; // R14 R20
            end
        end
    end
    genvar i;
    generate
        for (i = 0; i < SLOT_COUNT; i++) begin : gSlot
            always_ff @(posedge clk) begin
                if (reset) begin
                    slot_q[i] <= PAGE_RESET[2:0];
                end else if (clkEn && wrEn && pageOper == OPER_SAVE && slotSel == SLOT_W'(i)) begin
                    slot_q[i] <= page_q; // R13 R14 R18 R19
                end
            end
        end
    endgenerate
endmodule : sae_page_reg

/* File: hw/sae_device.sv */
// Address extension logic: map select register and paged module registers
//
// Behaviour
// R1 - Decode accesses in range 80 to FF
// R2 - Standard and mapped areas share addresses
// R3 - Area chosen by map bit at 8F
// R4 - Map bit zero standard, one mapped
// R5 - Hardware never clears map bit
// R6 - Control register resets 04, bit2 one
// R7 - Bits 7:5, 3, 1 read zero
// R8 - Software uses AND/OR on map bit
// R9 - Module page field selects visible registers
// R10 - Page count may differ per module
// R11 - Rewrite page before accessing other page
// R12 - Set map and page before paged access
// R13 - Four storage slots per page register
// R14 - Save writes old page, loads new
// R15 - Restore loads slot, ignores data page
// R16 - Paging for ports, converter, system control
// R17 - Page field bits 2:0, reads active
// R18 - Slot number bits 5:4, write-only
// R19 - Operation bits 7:6: save, restore
// R20 - Upper operation bit zero: direct write
// R21 - New setting effective on next access
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module sae_device (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    sae_if.device bus,
    output logic [7:0] controlReg,
    output logic accessValid
);
    import sae_pkg::*;
    logic [7:0] syscon_q;
    logic [7:0] rdata_q;
    logic [2:0] pages [MODULE_COUNT];
    logic [MODULE_COUNT-1:0] pageWr;
    logic [MODULE_COUNT-1:0] pageHit;
    logic [2:0] pageView;
    logic inRange;

    function automatic logic [7:0] syscon_view(input logic [7:0] stored);
        logic [7:0] v;
        v = stored & SYSCON_WMASK; // R7
        v[FIXED_ONE_BIT] = 1'b1; // R6
        return v;
    endfunction : syscon_view

    // Shared by write enable and read mux so both sides always agree on which page register is hit
    function automatic logic [MODULE_COUNT-1:0] page_hit(input logic [7:0] a, input logic mapSel);
        logic [MODULE_COUNT-1:0] h;
        h = '0;
        if (mapSel && a[7]) begin
            h[0] = a == PORT_PAGE_ADDR;
            h[1] = a == ADC_PAGE_ADDR;
            h[2] = a == SCU_PAGE_ADDR;
        end
        return h;
    endfunction : page_hit

    assign inRange = bus.addr[7]; // R1
    assign accessValid = inRange && (bus.rd || bus.wr);
    // Page registers live only in the mapped area; map bit is the stored one, so a map change applies from the next access
    assign pageHit = page_hit(bus.addr, syscon_q[MAP_SEL_BIT]); // R3 R4 R9
    assign pageWr = (clkEn && bus.wr) ? pageHit : '0;
    always_comb begin
        pageView = 3'h0;
        for (int j = 0; j < MODULE_COUNT; j++) begin
            if (pageHit[j]) begin
                pageView = pages[j];
            end
        end
    end
    genvar m;
    generate
        for (m = 0; m < MODULE_COUNT; m++) begin : gMod
            sae_page_reg sae_page_reg_inst ( // R16 R10
                .clk(clk),
                .reset(reset),
                .clkEn(clkEn),
                .wrEn(pageWr[m]),
                .wdata(bus.wdata),
                .page(pages[m])
            );
        end
    endgenerate
    // Control register is visible in both areas; only software changes the map bit
    always_ff @(posedge clk) begin
        if (reset) begin
            syscon_q <= SYSCON_RESET; // R6
        end else if (clkEn && bus.wr && bus.addr == SYSCON_ADDR) begin
            syscon_q <= syscon_view(bus.wdata); // R5 R7
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (clkEn && bus.rd) begin
            if (bus.addr == SYSCON_ADDR) begin
                rdata_q <= syscon_view(syscon_q);
            end else if (|pageHit) begin
                rdata_q <= {5'h00, pageView}; // R17
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end
    assign bus.rdata = rdata_q;
    assign bus.mapped = syscon_q[MAP_SEL_BIT]; // R2 R21
    assign bus.portPage = pages[0];
    assign bus.adcPage = pages[1];
    assign bus.scuPage = pages[2];
    assign controlReg = syscon_view(syscon_q);
endmodule : sae_device

/* File: hw/sae_core_end.sv */
// Processor-side end: runs one register access per software command
`timescale 1ns/1ps
module sae_core_end (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    sae_if.core bus
);
    import sae_pkg::*;
    sae_state_type state_q;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic isRead_q;
    logic [7:0] result_q;
    logic [7:0] regRdata_q;
    logic [7:0] target_q;
    logic goCmd;
    assign goCmd = clkEn && regWr && regAddr == CMD_GO && state_q == ST_IDLE;
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_q <= SFR_FIRST;
            wdata_q <= 8'h00;
        end else if (clkEn && regWr && regAddr == CMD_ADDR) begin
            addr_q <= regWdata;
        end else if (clkEn && regWr && regAddr == CMD_WDATA) begin
            wdata_q <= regWdata;
        end
    end
    // Software is expected to set map bit and page first; this end just issues the access
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            isRead_q <= 1'b0;
        end else if (clkEn) begin
            case (state_q)
                ST_IDLE: begin
                    if (goCmd) begin
                        isRead_q <= regWdata[0];
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: state_q <= ST_DONE;
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr = state_q == ST_ISSUE && !isRead_q; // R8 R11 R12
    assign bus.rd = state_q == ST_ISSUE && isRead_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            result_q <= 8'h00;
            target_q <= 8'h00;
        end else if (clkEn) begin
            if (state_q == ST_DONE && isRead_q) begin
                result_q <= bus.rdata;
            end
            target_q <= {bus.mapped, bus.scuPage[1:0], bus.adcPage[1:0], bus.portPage};
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            regRdata_q <= 8'h00;
        end else if (clkEn && regRd) begin
            case (regAddr)
                CMD_ADDR: regRdata_q <= addr_q;
                CMD_WDATA: regRdata_q <= wdata_q;
                CMD_STATUS: regRdata_q <= {7'h00, state_q != ST_IDLE};
                CMD_RDATA: regRdata_q <= result_q;
                CMD_TARGET: regRdata_q <= target_q;
                default: regRdata_q <= 8'h00;
            endcase
        end
    end
    assign regRdata = regRdata_q;
endmodule : sae_core_end

/* File: bench/sae_link_monitor.sv */
// Concurrent checks on the access link between the two ends
`timescale 1ns/1ps
module sae_link_monitor
    import sae_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic mapped,
    input wire logic [2:0] portPage,
    input wire logic [2:0] adcPage,
    input wire logic [2:0] scuPage
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic mapBit;
    logic [2:0] wrPage;
    assign mapBit = wdata[MAP_SEL_BIT];
    assign wrPage = wdata[PAGE_LSB +: PAGE_W];
    property p_mapLoad; wr && addr == SYSCON_ADDR |=> mapped == $past(mapBit); endproperty
    a_mapLoad: assert property (p_mapLoad) else $error("map bit not loaded");
    property p_mapHold; !(wr && addr == SYSCON_ADDR) |=> $stable(mapped); endproperty
    a_mapHold: assert property (p_mapHold) else $error("map bit changed alone");
    // Interrupt mode bit is not visible on the link, so only the fixed bits and the map bit are checked
    property p_ctrlRead; rd && addr == SYSCON_ADDR |=> {rdata[7:5], rdata[3:0]} == {6'h02, $past(mapped)};
    endproperty
    a_ctrlRead: assert property (p_ctrlRead) else $error("control read");
    property p_lowRead; rd && addr < SFR_FIRST |=> rdata == 8'h00; endproperty
    a_lowRead: assert property (p_lowRead) else $error("low address read");
    property p_direct; wr && mapped && addr == PORT_PAGE_ADDR && !wdata[7] |=> portPage == $past(wrPage);
    endproperty
    a_direct: assert property (p_direct) else $error("direct page write");
    property p_save; wr && mapped && addr == ADC_PAGE_ADDR && wdata[7:6] == 2'b10 |=> adcPage == $past(wrPage);
    endproperty
    a_save: assert property (p_save) else $error("save page load");
    property p_pageRead; rd && mapped && addr == SCU_PAGE_ADDR |=> rdata == {5'h00, $past(scuPage)}; endproperty
    a_pageRead: assert property (p_pageRead) else $error("page read");
    property p_stdArea; wr && !mapped && addr == PORT_PAGE_ADDR |=> $stable(portPage); endproperty
    a_stdArea: assert property (p_stdArea) else $error("page written unmapped");
    c_restore: cover property (wr && mapped && wdata[7:6] == 2'b11);
    c_save: cover property (wr && mapped && wdata[7:6] == 2'b10);
    c_mapSet: cover property ($rose(mapped));
endmodule : sae_link_monitor

/* File: bench/sae_device_tb.sv */
// Self-checking bench joining the processor-side end and the extension logic
`timescale 1ns/1ps
module sae_device_tb;
    import sae_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic clkEn = 1'b1;
    int validCount = 0;
    int expValid = 0;
    logic [7:0] regRdata, controlReg, rd, d;
    logic accessValid;
    logic [2:0] seen;
    int num_errors = 0;
    int num_checks = 0;
    int k;
    logic [7:0] pageAddr [3] = '{PORT_PAGE_ADDR, ADC_PAGE_ADDR, SCU_PAGE_ADDR};
    logic [2:0] pages [3] = '{default: 3'h0};
    logic [2:0] slots [3][4] = '{default: 3'h0};
    sae_if link ();
    always #2.5 clk = ~clk;
    sae_device sae_device_inst (.clk(clk), .reset(reset), .clkEn(clkEn), .bus(link), .controlReg(controlReg),
        .accessValid(accessValid));
    sae_core_end sae_core_end_inst (.clk(clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .bus(link));
    sae_link_monitor sae_link_monitor_inst (.clk(clk), .reset(reset), .addr(link.addr), .wdata(link.wdata),
        .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .mapped(link.mapped), .portPage(link.portPage),
        .adcPage(link.adcPage), .scuPage(link.scuPage));
    // Each issued access in the register range must raise the valid flag for exactly one cycle
    always @(posedge clk) begin
        if (!reset && accessValid) begin
            validCount <= validCount + 1;
        end
    end
    function automatic logic [2:0] nextPage(logic [2:0] slotVal, logic [7:0] v);
        return (v[7:6] == 2'b11) ? slotVal : v[2:0];
    endfunction : nextPage
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic regWrite(logic [3:0] a, logic [7:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic regRead(logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        v = regRdata;
    endtask : regRead
    // Runs one link access through the command registers and waits for idle
    task automatic access(logic isRead, logic [7:0] a, logic [7:0] v, output logic [7:0] res);
        logic [7:0] st;
        if (a[7]) begin
            expValid++;
        end
        regWrite(CMD_ADDR, a);
        regWrite(CMD_WDATA, v);
        regWrite(CMD_GO, {7'h00, isRead});
        for (int n = 0; n < 8; n++) begin
            regRead(CMD_STATUS, st);
            if (st[0] === 1'b0) break;
            if (n == 7) begin
                num_errors++;
                $display("Error busy expected 0 seen %h", st[0]);
                stop_test();
            end
        end
        regRead(CMD_RDATA, res);
    endtask : access
    initial begin
        rd = 8'($urandom(99));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        access(1'b1, SYSCON_ADDR, 8'h00, rd);
        check("control reset", SYSCON_RESET, rd);
        access(1'b0, PORT_PAGE_ADDR, 8'h05, rd);
        check("unmapped page", 8'h00, {5'h00, link.portPage});
        // Map bit is changed by read-modify-write so the other control bits keep their value
        access(1'b1, SYSCON_ADDR, 8'h00, rd);
        access(1'b0, SYSCON_ADDR, rd | 8'h01, rd);
        access(1'b1, SYSCON_ADDR, 8'h00, rd);
        check("control set", SYSCON_RESET | 8'h01, rd);
        check("control view", SYSCON_RESET | 8'h01, controlReg);
        $display("Test mapping done");
        // Operation codes cycle through all four while slot and page stay random
        for (int i = 0; i < 24; i++) begin
            k = i % 3;
            d = {2'(i / 3), 6'($urandom) & 6'h37};
            seen = pages[k];
            pages[k] = nextPage(slots[k][d[5:4]], d);
            if (d[7:6] == 2'b10) begin
                slots[k][d[5:4]] = seen;
            end
            access(1'b0, pageAddr[k], d, rd);
            access(1'b1, pageAddr[k], 8'h00, rd);
            check("page read", {5'h00, pages[k]}, rd);
            check("port adc", {2'b00, pages[0], pages[1]}, {2'b00, link.portPage, link.adcPage});
            check("map scu", {4'h0, 1'b1, pages[2]}, {4'h0, link.mapped, link.scuPage});
        end
        regRead(CMD_TARGET, rd);
        check("target", {1'b1, pages[2][1:0], pages[1][1:0], pages[0]}, rd);
        $display("Test paging done");
        access(1'b1, 8'h10, 8'h00, rd);
        check("low address", 8'h00, rd);
        access(1'b1, SYSCON_ADDR, 8'h00, rd);
        access(1'b0, SYSCON_ADDR, rd | 8'h10, rd);
        access(1'b1, SYSCON_ADDR, 8'h00, rd);
        check("interrupt mode", SYSCON_RESET | SYSCON_WMASK, rd);
        access(1'b0, SYSCON_ADDR, rd & 8'hFE, rd);
        access(1'b1, PORT_PAGE_ADDR, 8'h00, rd);
        check("standard area", 8'h00, rd);
        check("map clear", 8'h00, {7'h00, link.mapped});
        check("valid count", 8'(expValid), 8'(validCount));
        $display("Test areas done");
        // A command written while the enable is low must leave the address register untouched
        @(posedge clk);
        clkEn <= 1'b0;
        regWrite(CMD_ADDR, 8'h00);
        clkEn <= 1'b1;
        regRead(CMD_ADDR, rd);
        check("frozen address", PORT_PAGE_ADDR, rd);
        $display("Test freeze done");
        stop_test();
    end
endmodule : sae_device_tb
